// ==== bench/tb.sv ====
// Purpose: Self-checking bench for the clamp timing block.
// Assumes: Source model supplies sync and video.
// Notes: Divider pin held constant.
`timescale 1ns/100ps
`default_nettype none
module tb
  import vct_pkg::*;
;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce_in = 1'b1;
  logic reg_wr_in = 1'b0;
  logic [3:0] reg_idx_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic ext_clamp_in = 1'b0;
  logic run = 1'b0;
  logic [7:0] level = 8'h10;
  logic hsync_in;
  logic [23:0] sample_in;
  logic [7:0] reg_rdata_out;
  logic clamp_out;
  logic [23:0] range_out;
  logic [17:0] shift_out;
  logic [17:0] trim_out;
  logic wrap;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int off;
  int len;
  logic [7:0] rv [9] = '{8'h08, 8'h14, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] dv [5] = '{8'h08, 8'h00, 8'h01, 8'h40, 8'h10};
  logic [7:0] wv [5] = '{8'h14, 8'h01, 8'h03, 8'h10, 8'h00};
  always #10 clk_in = ~clk_in;
  vct_src_model u_src (.clk_in(clk_in), .run_in(run), .level_in(level),
    .hsync_out(hsync_in), .sample_out(sample_in));
  vct_clamp_timing u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .reg_wr_in(reg_wr_in), .reg_idx_in(reg_idx_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .hsync_in(hsync_in), .ext_clamp_in(ext_clamp_in),
    .pixel_clock_divider_in(12'h05f), .sample_in(sample_in), .clamp_out(clamp_out),
    .range_out(range_out), .shift_out(shift_out), .trim_out(trim_out), .divider_wrap_out(wrap));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_idx_in <= i;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] i, input logic [7:0] exp);
    @(posedge clk_in);
    reg_idx_in <= i;
    repeat (2) @(posedge clk_in);
    chk({16'h0, reg_rdata_out}, {16'h0, exp});
  endtask
  // Measures one line: first clamp pixel after the trailing edge, and clamp length.
  task automatic line(output int o, output int n);
    o = 0;
    n = 0;
    while (hsync_in !== 1'b1) @(posedge clk_in);
    while (hsync_in !== 1'b0) @(posedge clk_in);
    for (int k = 0; hsync_in === 1'b0; k++)
    begin
      if (clamp_out === 1'b1 && n == 0) o = k;
      if (clamp_out === 1'b1) n++;
      @(posedge clk_in);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      close_out();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 9; i++) rdc(i[3:0], rv[i]);
    rdc(VCT_IDX_STATUS, 8'h00);
    for (int i = 0; i < 8; i++) wr(i[3:0], 8'hff);
    wr(VCT_IDX_STATUS, 8'hff);
    for (int i = 0; i < 8; i++) rdc(i[3:0], i < 5 ? 8'hff : 8'h3f);
    rdc(4'ha, 8'h00);
    chk(range_out, 24'hffffff);
    chk({6'h0, shift_out}, 24'h03ffff);
    for (int i = 2; i < 5; i++) wr(i[3:0], 8'h00);
    repeat (2) @(posedge clk_in);
    chk(range_out, 24'h000000);
    $display("end registers");
    run <= 1'b1;
    for (int j = 0; j < 5; j++)
    begin
      wr(VCT_IDX_START_DELAY, dv[j]);
      wr(VCT_IDX_WIDTH, wv[j]);
      line(off, len);
      chk(24'(len), {16'h0, wv[j]});
      if (wv[j] != 8'h00) chk(24'(off), 24'(dv[j] == 8'h00 ? 3 : dv[j] + 2));
    end
    // The divider pin is 95, so the pixel count wraps once every 96 pixels.
    while (wrap !== 1'b1) @(posedge clk_in);
    @(posedge clk_in);
    len = 1;
    while (wrap !== 1'b1)
    begin
      @(posedge clk_in);
      len++;
    end
    chk(24'(len), 24'h000060);
    $display("end internal window");
    chk({6'h0, trim_out}, {3{6'h21}});
    level <= 8'h00;
    ce_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    ce_in <= 1'b1;
    line(off, len);
    chk({6'h0, trim_out}, {3{6'h21}});
    $display("end trim");
    for (int m = 0; m < 4; m++)
    begin
      wr(VCT_IDX_MODE, {6'h00, m[1], 1'b1});
      rdc(VCT_IDX_MODE, {6'h00, m[1], 1'b1});
      @(posedge clk_in);
      ext_clamp_in <= m[0];
      repeat (2) @(posedge clk_in);
      chk({23'h0, clamp_out}, {23'h0, m[0] == m[1]});
    end
    wr(VCT_IDX_MODE, 8'h00);
    $display("end external clamp");
    close_out();
  end
endmodule // tb
`default_nettype wire

// ==== bench/vct_clamp_timing_asserts.sv ====
// Purpose: Port assertions for the clamp timing block.
// Assumes: One pixel clock; shadows follow register writes.
// Notes: Window figures follow the hand-over walk.
`timescale 1ns/100ps
`default_nettype none
module vct_clamp_timing_asserts
  import vct_pkg::*;
#(
  parameter int DIV_WIDTH = 12
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic [3:0] reg_idx_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // Pins and outputs
  input wire logic hsync_in,
  input wire logic ext_clamp_in,
  input wire logic clamp_out,
  input wire logic [23:0] range_out,
  input wire logic [17:0] trim_out
);
  logic [7:0] dly_q;
  logic [7:0] wid_q;
  logic [1:0] mode_q;
  logic hs_q;
  logic [9:0] cnt_q;
  logic [9:0] beg;
  logic win;
  logic wr_ok;
  assign wr_ok = ce_in && reg_wr_in;
  assign beg = (dly_q == 8'h00) ? 10'h003 : {2'h0, dly_q} + 10'h002;
  assign win = (cnt_q >= beg) && (cnt_q < beg + {2'h0, wid_q});
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      dly_q <= VCT_RST_START_DELAY;
      wid_q <= VCT_RST_WIDTH;
      mode_q <= 2'h0;
    end
    else if (wr_ok)
    begin
      if (reg_idx_in == VCT_IDX_START_DELAY) dly_q <= reg_wdata_in;
      if (reg_idx_in == VCT_IDX_WIDTH) wid_q <= reg_wdata_in;
      if (reg_idx_in == VCT_IDX_MODE) mode_q <= reg_wdata_in[1:0];
    end
  end
  // Saturating count of pixels since the last sync trailing edge.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      hs_q <= 1'b0;
      cnt_q <= 10'h3ff;
    end
    else if (ce_in)
    begin
      hs_q <= hsync_in;
      cnt_q <= (hs_q && !hsync_in) ? 10'h001 : cnt_q + {9'h0, cnt_q != 10'h3ff};
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence quiet3;
    (!clamp_out)[*3];
  endsequence
  clamp_window_a: assert property (!mode_q[0] && !$past(mode_q[0]) |-> clamp_out == win)
    else $error("clamp window misplaced");
  ext_follow_a: assert property (ce_in && mode_q[0] |=>
    clamp_out == ($past(ext_clamp_in) == $past(mode_q[1]))) else $error("clamp pin not followed");
  delay_read_a: assert property (ce_in && !reg_wr_in && reg_idx_in == VCT_IDX_START_DELAY
    |=> reg_rdata_out == dly_q) else $error("delay readback wrong");
  width_read_a: assert property (ce_in && !reg_wr_in && reg_idx_in == VCT_IDX_WIDTH
    |=> reg_rdata_out == wid_q) else $error("width readback wrong");
  unmapped_zero_a: assert property (ce_in && reg_idx_in > VCT_IDX_STATUS |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  trim_floor_a: assert property (trim_out[5:0] != 6'h20 && trim_out[11:6] != 6'h20
    && trim_out[17:12] != 6'h20) else $error("trim beyond range");
  trim_hold_a: assert property (quiet3 |-> $stable(trim_out))
    else $error("trim moved outside clamp");
  ce_freeze_a: assert property (!ce_in |=> $stable(clamp_out) && $stable(range_out))
    else $error("outputs moved while disabled");
endmodule // vct_clamp_timing_asserts
bind vct_clamp_timing vct_clamp_timing_asserts #(.DIV_WIDTH(DIV_WIDTH)) u_chk (.*);
`default_nettype wire

// ==== bench/vct_src_model.sv ====
// Purpose: Graphics source with line sync and flat video.
// Assumes: Line of 96 pixels, sync high for the first 8.
// Notes: Sync stays low while not running.
`timescale 1ns/100ps
`default_nettype none
module vct_src_model
(
  // Control
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic [7:0] level_in,
  // Video side
  output logic hsync_out,
  output logic [23:0] sample_out
);
  logic [6:0] pos_q = 7'h00;
  always_ff @(posedge clk_in)
  begin
    pos_q <= (!run_in || pos_q == 7'h5f) ? 7'h00 : pos_q + 7'h01;
  end
  assign hsync_out = run_in && (pos_q < 7'h08);
  assign sample_out = {3{level_in}};
endmodule // vct_src_model
`default_nettype wire

// ==== logic/vct_clamp_timing.sv ====
// Purpose: Clamp window generation, gain and offset registers, offset trim.
// Assumes: clk_in is the pixel clock recovered from horizontal sync.
// Notes: Registers are written through a plain index/data write port.
// Function
// - External clamp select set means the clamp pin sets the window.
// - Clamp pin active level follows the polarity bit.
// - Internal window starts after start delay pixels past sync trailing edge; the code treats a delay of 0 as 1.
// - Internal window lasts clamp width pixels.
// - Start delay and width are unsigned 8-bit values.
// - During clamp, offset is trimmed toward code 00h and held after.
// - Each channel has an 8-bit range code, 0 minimum, 255 maximum.
// - Each channel has a 6-bit offset code, plus or minus 31 LSB.
// - Pixel clock loop divides by the programmed divider plus one, locked to sync.
`timescale 1ns/100ps
`default_nettype none
module vct_clamp_timing
  import vct_pkg::*;
#(
  parameter int DIV_WIDTH = 12
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Register write and read port
  input wire logic reg_wr_in,
  input wire logic [3:0] reg_idx_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Sync, clamp, divider and sample inputs
  input wire logic hsync_in,
  input wire logic ext_clamp_in,
  input wire logic [DIV_WIDTH-1:0] pixel_clock_divider_in,
  input wire logic [23:0] sample_in,
  // Outputs
  output logic clamp_out,
  output logic [23:0] range_out,
  output logic [17:0] shift_out,
  output logic [17:0] trim_out,
  output logic divider_wrap_out
);
  // The pixel counter is built for a 12-bit divider only; refuse any other width.
  generate
    if (DIV_WIDTH != 12)
    begin : g_bad_width
      $error("DIV_WIDTH must be 12");
    end
  endgenerate
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] clamp_start_delay_q;
  logic [7:0] clamp_width_q;
  logic [7:0] range_q [VCT_CHANNELS];
  logic [5:0] shift_q [VCT_CHANNELS];
  logic ext_window_select_q;
  logic ext_window_polarity_q;
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      clamp_start_delay_q <= VCT_RST_START_DELAY;
      clamp_width_q <= VCT_RST_WIDTH;
      ext_window_select_q <= 1'b0;
      ext_window_polarity_q <= 1'b0;
      for (int i = 0; i < VCT_CHANNELS; i++)
      begin
        range_q[i] <= VCT_RST_RANGE;
        shift_q[i] <= VCT_RST_SHIFT;
      end
    end
    else if (ce_in && reg_wr_in)
    begin
      case (reg_idx_in)
        VCT_IDX_START_DELAY: clamp_start_delay_q <= reg_wdata_in;
        VCT_IDX_WIDTH: clamp_width_q <= reg_wdata_in;
        VCT_IDX_CH1_RANGE: range_q[0] <= reg_wdata_in;
        VCT_IDX_CH2_RANGE: range_q[1] <= reg_wdata_in;
        VCT_IDX_CH3_RANGE: range_q[2] <= reg_wdata_in;
        VCT_IDX_CH1_SHIFT: shift_q[0] <= reg_wdata_in[5:0];
        VCT_IDX_CH2_SHIFT: shift_q[1] <= reg_wdata_in[5:0];
        VCT_IDX_CH3_SHIFT: shift_q[2] <= reg_wdata_in[5:0];
        VCT_IDX_MODE:
        begin
          ext_window_select_q <= reg_wdata_in[VCT_MODE_SELECT_BIT];
          ext_window_polarity_q <= reg_wdata_in[VCT_MODE_POLARITY_BIT];
        end
        default: ;
      endcase
    end
  end
  // ----------------------------------------
  // Internal window
  // ----------------------------------------
  vct_state_type state_q;
  logic [7:0] cnt_q;
  logic hsync_q;
  logic trail;
  assign trail = hsync_q && !hsync_in;
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      hsync_q <= 1'b0;
    else if (ce_in)
      hsync_q <= hsync_in;
  end
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_q <= VCT_IDLE;
      cnt_q <= 8'h00;
    end
    else if (ce_in)
    begin
      if (trail)
      begin
        cnt_q <= 8'h00;
        state_q <= VCT_WAIT;
      end
      else
      begin
        case (state_q)
          VCT_WAIT:
            if (cnt_q + 8'h01 >= clamp_start_delay_q)
            begin
              cnt_q <= 8'h00;
              state_q <= (clamp_width_q == 8'h00) ? VCT_IDLE : VCT_CLAMP;
            end
            else
              cnt_q <= cnt_q + 8'h01;
          VCT_CLAMP:
            if (cnt_q + 8'h01 >= clamp_width_q)
            begin
              cnt_q <= 8'h00;
              state_q <= VCT_IDLE;
            end
            else
              cnt_q <= cnt_q + 8'h01;
          default: cnt_q <= 8'h00;
        endcase
      end
    end
  end
  // ----------------------------------------
  // Window select and outputs
  // ----------------------------------------
  logic window_d;
  // Polarity bit high means the pin is active high.
  assign window_d = ext_window_select_q ? (ext_clamp_in == ext_window_polarity_q)
                  : (state_q == VCT_CLAMP);
  vct_cal_if cal ();
  assign cal.clamp_active = clamp_out;
  assign cal.sample = sample_in;
  vct_offset_track u_track (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .cal(cal)
  );
  logic wrap;
  vct_div_count u_div (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .line_start_in(trail),
    .divider_in(pixel_clock_divider_in),
    .wrap_out(wrap)
  );
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      clamp_out <= 1'b0;
      range_out <= 24'h000000;
      shift_out <= 18'h00000;
      trim_out <= 18'h00000;
      divider_wrap_out <= 1'b0;
      reg_rdata_out <= 8'h00;
    end
    else if (ce_in)
    begin
      clamp_out <= window_d;
      range_out <= {range_q[2], range_q[1], range_q[0]};
      shift_out <= {shift_q[2], shift_q[1], shift_q[0]};
      trim_out <= cal.trim;
      divider_wrap_out <= wrap;
      case (reg_idx_in)
        VCT_IDX_START_DELAY: reg_rdata_out <= clamp_start_delay_q;
        VCT_IDX_WIDTH: reg_rdata_out <= clamp_width_q;
        VCT_IDX_CH1_RANGE: reg_rdata_out <= range_q[0];
        VCT_IDX_CH2_RANGE: reg_rdata_out <= range_q[1];
        VCT_IDX_CH3_RANGE: reg_rdata_out <= range_q[2];
        VCT_IDX_CH1_SHIFT: reg_rdata_out <= {2'b00, shift_q[0]};
        VCT_IDX_CH2_SHIFT: reg_rdata_out <= {2'b00, shift_q[1]};
        VCT_IDX_CH3_SHIFT: reg_rdata_out <= {2'b00, shift_q[2]};
        VCT_IDX_MODE: reg_rdata_out <= {6'h00, ext_window_polarity_q, ext_window_select_q};
        VCT_IDX_STATUS: reg_rdata_out <= {7'h00, clamp_out};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end
endmodule // vct_clamp_timing
`default_nettype wire

// ==== logic/vct_div_count.sv ====
// Purpose: Pixel count within the line, reference for the clock loop.
// Assumes: Pixel clock is the recovered clock.
// Notes: Flags when the count reaches the programmed divider value.
`timescale 1ns/100ps
`default_nettype none
module vct_div_count
  import vct_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Control
  input wire logic line_start_in,
  input wire logic [11:0] divider_in,
  // Status
  output logic wrap_out
);
  logic [11:0] cnt_q;
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnt_q <= 12'h000;
      wrap_out <= 1'b0;
    end
    else if (ce_in)
    begin
      wrap_out <= (cnt_q == divider_in);
      if (line_start_in || cnt_q == divider_in)
        cnt_q <= 12'h000;
      else
        cnt_q <= cnt_q + 12'h001;
    end
  end
endmodule // vct_div_count
`default_nettype wire

// ==== logic/vct_offset_track.sv ====
// Purpose: Black-level offset trim per channel during the clamp window.
// Assumes: Samples are converter codes of the current pixel.
// Notes: Trim is a signed six-bit correction, held between clamps.
`timescale 1ns/100ps
`default_nettype none
module vct_offset_track
  import vct_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Calibration link
  vct_cal_if.dst cal
);
  logic [17:0] trim_q;
  genvar g;
  generate
    for (g = 0; g < VCT_CHANNELS; g++)
    begin : g_ch
      always_ff @(posedge clk_in or negedge rstn_in)
      begin
        if (!rstn_in)
          trim_q[g*6 +: 6] <= 6'h00;
        else if (ce_in && cal.clamp_active)
        begin
          // Step by one code per pixel; a slow loop rides out noise on the porch.
          if (cal.sample[g*8 +: 8] != VCT_BLACK_CODE && trim_q[g*6 +: 6] != 6'h21)
            trim_q[g*6 +: 6] <= trim_q[g*6 +: 6] - 6'h01;
        end
      end
    end
  endgenerate
  assign cal.trim = trim_q;
endmodule // vct_offset_track
`default_nettype wire

// ==== pkg/vct_cal_if.sv ====
// Purpose: Carries clamp window and black-level sample to the offset tracker.
// Assumes: Single clock domain.
// Notes: None.
`timescale 1ns/100ps
`default_nettype none
interface vct_cal_if;
  logic clamp_active;
  logic [23:0] sample;
  logic [17:0] trim;
  modport src (output clamp_active, output sample, input trim);
  modport dst (input clamp_active, input sample, output trim);
endinterface
`default_nettype wire

// ==== pkg/vct_pkg.sv ====
// Purpose: Shared constants for the video clamp timing generator.
// Assumes: One pixel clock domain, registers loaded over a plain write port.
// Notes: Register indices are local choices; widths follow the hardware.
package vct_pkg;
  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [3:0] VCT_IDX_START_DELAY = 4'h0;
  localparam logic [3:0] VCT_IDX_WIDTH = 4'h1;
  localparam logic [3:0] VCT_IDX_CH1_RANGE = 4'h2;
  localparam logic [3:0] VCT_IDX_CH2_RANGE = 4'h3;
  localparam logic [3:0] VCT_IDX_CH3_RANGE = 4'h4;
  localparam logic [3:0] VCT_IDX_CH1_SHIFT = 4'h5;
  localparam logic [3:0] VCT_IDX_CH2_SHIFT = 4'h6;
  localparam logic [3:0] VCT_IDX_CH3_SHIFT = 4'h7;
  localparam logic [3:0] VCT_IDX_MODE = 4'h8;
  localparam logic [3:0] VCT_IDX_STATUS = 4'h9;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int VCT_MODE_SELECT_BIT = 0;
  localparam int VCT_MODE_POLARITY_BIT = 1;
  localparam logic [7:0] VCT_RST_START_DELAY = 8'h08;
  localparam logic [7:0] VCT_RST_WIDTH = 8'h14;
  localparam logic [7:0] VCT_RST_RANGE = 8'h80;
  localparam logic [5:0] VCT_RST_SHIFT = 6'h00;
  localparam logic [7:0] VCT_RST_DIVIDER = 8'h00;
  localparam logic [7:0] VCT_BLACK_CODE = 8'h00;
  localparam int VCT_CHANNELS = 3;
  typedef enum {VCT_IDLE, VCT_WAIT, VCT_CLAMP} vct_state_type;
endpackage
